//--- core/gas_pin_select.sv
// output source selection for the two general-purpose pins
//
// Summary of operation
// - second pin codes 05/06/07 copy LED pulses
// - second pin codes 0c/0d/0e show data cycles
// - second pin code 0f toggles every sample
// - second pin 10 low, 11 high; 12 and codes above 13 unsupported
// - second pin code 13 outputs slow oscillator
// - first selector bits 4:0, bits 7:5 reserved
// - first pin code 0 gives legacy interrupt behaviour
// - first pin code 1 gives interrupt function
// - code 2: first slot start to last slot end
// - first pin codes 5/6/7 output LED pulses
// - first pin codes c/d/e show data cycles
// - first pin code f toggles every sample
// - second selector bits 12:8; codes 01, 02
// - first pin floats unless enabled; polarity selectable
// - drive style set: drive only while active
`timescale 1ns/10ps
`default_nettype none

module gas_pin_select #(
  parameter int unsigned NUM_PINS = 2
) (
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  // register port of the device
  input  wire logic                        reg_wr_en,
  input  wire logic                        reg_rd_en,
  input  wire logic [gas_pkg::REG_AW-1:0]  reg_addr,
  input  wire logic [gas_pkg::REG_DW-1:0]  reg_wdata,
  output logic      [gas_pkg::REG_DW-1:0]  reg_rdata,
  // event sources from the timing engine and interrupt logic
  input  wire logic                        intr_level,
  input  wire logic                        slot_first_start,
  input  wire logic                        slot_last_end,
  input  wire logic                        slot_a_led,
  input  wire logic                        slot_b_led,
  input  wire logic                        slot_a_data,
  input  wire logic                        slot_b_data,
  input  wire logic                        sample_tick,
  input  wire logic                        osc_slow_clk,
  // pins
  output logic                             first_general_pin_out,
  output logic                             first_general_pin_oe,
  output logic                             second_general_pin_out,
  output logic                             second_general_pin_oe
);

  // ---------------- address decode ----------------
  logic hit_alt_sel;
  logic hit_pin_cfg;
  logic wr_alt_sel;
  logic wr_pin_cfg;
  logic rd_alt_sel;
  logic rd_pin_cfg;

  always_comb begin
    hit_alt_sel = (reg_addr == gas_pkg::ADDR_ALT_SEL);
    hit_pin_cfg = (reg_addr == gas_pkg::ADDR_PIN_CFG);
    wr_alt_sel  = reg_wr_en & hit_alt_sel;
    wr_pin_cfg  = reg_wr_en & hit_pin_cfg;
    rd_alt_sel  = reg_rd_en & hit_alt_sel;
    rd_pin_cfg  = reg_rd_en & hit_pin_cfg;
  end

  // ---------------- selector fields ----------------
  logic [gas_pkg::SEL_W-1:0] sel_q [NUM_PINS];
  logic [gas_pkg::SEL_W-1:0] sel_d [NUM_PINS];

  genvar si;
  generate
    for (si = 0; si < NUM_PINS; si++) begin : g_sel
      // reserved bits between the fields are not stored and read back as zero
      localparam int unsigned LSB = (si == 0) ? gas_pkg::SEL0_LSB : gas_pkg::SEL1_LSB;

      always_comb begin
        sel_d[si] = sel_q[si];
        if (wr_alt_sel) begin
          sel_d[si] = reg_wdata[LSB +: gas_pkg::SEL_W];
        end
      end

      always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
          sel_q[si] <= gas_pkg::SEL_RST;
        end else begin
          sel_q[si] <= sel_d[si];
        end
      end
    end
  endgenerate

  // ---------------- first pin configuration ----------------
  logic ena_q;
  logic ena_d;
  logic drv_q;
  logic drv_d;
  logic pol_q;
  logic pol_d;

  always_comb begin
    ena_d = ena_q;
    drv_d = drv_q;
    pol_d = pol_q;
    if (wr_pin_cfg) begin
      ena_d = reg_wdata[gas_pkg::ENA_BIT];
      drv_d = reg_wdata[gas_pkg::DRV_BIT];
      pol_d = reg_wdata[gas_pkg::POL_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ena_q <= gas_pkg::ENA_RST;
      drv_q <= gas_pkg::DRV_RST;
      pol_q <= gas_pkg::POL_RST;
    end else begin
      ena_q <= ena_d;
      drv_q <= drv_d;
      pol_q <= pol_d;
    end
  end

  // ---------------- readback ----------------
  // read data is held until the next read so the host may sample it late
  logic [gas_pkg::REG_DW-1:0] rdata_q;
  logic [gas_pkg::REG_DW-1:0] rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd_en) begin
      // unmapped indexes and reserved bits read as zero
      rdata_d = '0;
    end
    if (rd_alt_sel) begin
      rdata_d[gas_pkg::SEL0_LSB +: gas_pkg::SEL_W] = sel_q[0];
      rdata_d[gas_pkg::SEL1_LSB +: gas_pkg::SEL_W] = sel_q[1];
    end
    if (rd_pin_cfg) begin
      rdata_d[gas_pkg::ENA_BIT] = ena_q;
      rdata_d[gas_pkg::DRV_BIT] = drv_q;
      rdata_d[gas_pkg::POL_BIT] = pol_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q <= gas_pkg::RDATA_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------- sample window ----------------
  // window and half-rate toggle are shared by both pins so they stay in phase
  logic window_q;
  logic window_d;

  always_comb begin
    window_d = window_q;
    // start wins if both arrive together: a new sample begins
    if (slot_last_end) begin
      window_d = 1'b0;
    end
    if (slot_first_start) begin
      window_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      window_q <= gas_pkg::WIN_RST;
    end else begin
      window_q <= window_d;
    end
  end

  // ---------------- half-rate toggle ----------------
  logic toggle_q;
  logic toggle_d;

  always_comb begin
    toggle_d = toggle_q;
    if (sample_tick) begin
      toggle_d = ~toggle_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      toggle_q <= gas_pkg::TOG_RST;
    end else begin
      toggle_q <= toggle_d;
    end
  end

  // ---------------- per-pin source mux ----------------
  logic [NUM_PINS-1:0] act;
  logic [NUM_PINS-1:0] legacy_src;

  // first pin: legacy interrupt pin; second pin: legacy sample-done output
  assign legacy_src[0] = intr_level;
  assign legacy_src[1] = slot_a_data | slot_b_data;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      always_comb begin
        case (gas_pkg::gas_sel_t'(sel_q[gi]))
          gas_pkg::SEL_LEGACY: begin
            act[gi] = legacy_src[gi];
          end
          gas_pkg::SEL_INTR: begin
            act[gi] = intr_level;
          end
          gas_pkg::SEL_WINDOW: begin
            act[gi] = window_q;
          end
          gas_pkg::SEL_LED_A: begin
            act[gi] = slot_a_led;
          end
          gas_pkg::SEL_LED_B: begin
            act[gi] = slot_b_led;
          end
          gas_pkg::SEL_LED_AB: begin
            act[gi] = slot_a_led | slot_b_led;
          end
          gas_pkg::SEL_DATA_A: begin
            act[gi] = slot_a_data;
          end
          gas_pkg::SEL_DATA_B: begin
            act[gi] = slot_b_data;
          end
          gas_pkg::SEL_DATA_ANY: begin
            act[gi] = slot_a_data | slot_b_data;
          end
          gas_pkg::SEL_TOGGLE: begin
            act[gi] = toggle_q;
          end
          gas_pkg::SEL_LOW: begin
            act[gi] = 1'b0;
          end
          gas_pkg::SEL_HIGH: begin
            act[gi] = 1'b1;
          end
          gas_pkg::SEL_OSC: begin
            act[gi] = osc_slow_clk;
          end
          // unsupported codes park the pin inactive
          default: begin
            act[gi] = 1'b0;
          end
        endcase
      end
    end
  endgenerate

  // ---------------- pin drivers ----------------
  // every pin level comes from a flop, so a selector write or a mux change
  // cannot put a combinational glitch on the pin; cost is one cycle of delay
  logic pin0_out_q;
  logic pin0_out_d;
  logic pin0_oe_q;
  logic pin0_oe_d;
  logic pin1_out_q;
  logic pin1_out_d;
  logic pin1_oe_q;
  logic pin1_oe_d;

  // first pin: polarity and open-drain style apply here only
  always_comb begin
    pin0_out_d = act[0] ^ pol_q;
    // open-drain style drives only while the selected signal is active
    pin0_oe_d  = ena_q & (~drv_q | act[0]);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin0_out_q <= gas_pkg::PIN_OUT_RST;
      pin0_oe_q  <= gas_pkg::PIN_OE_RST;
    end else begin
      pin0_out_q <= pin0_out_d;
      pin0_oe_q  <= pin0_oe_d;
    end
  end

  // second pin: always driven once out of reset, no polarity control
  always_comb begin
    pin1_out_d = act[1];
    pin1_oe_d  = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin1_out_q <= gas_pkg::PIN_OUT_RST;
      pin1_oe_q  <= gas_pkg::PIN_OE_RST;
    end else begin
      pin1_out_q <= pin1_out_d;
      pin1_oe_q  <= pin1_oe_d;
    end
  end

  assign first_general_pin_out  = pin0_out_q;
  assign first_general_pin_oe   = pin0_oe_q;
  assign second_general_pin_out = pin1_out_q;
  assign second_general_pin_oe  = pin1_oe_q;

endmodule : gas_pin_select

`default_nettype wire

//--- core/gas_pkg.sv
// constants and types for the general pin output selector
package gas_pkg;

  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 16;
  localparam int unsigned SEL_W  = 5;

  // register offsets
  localparam logic [REG_AW-1:0] ADDR_PIN_CFG = 8'h02;
  localparam logic [REG_AW-1:0] ADDR_ALT_SEL = 8'h0b;

  // field positions
  localparam int unsigned SEL0_LSB = 0;
  localparam int unsigned SEL1_LSB = 8;
  localparam int unsigned POL_BIT  = 0;
  localparam int unsigned DRV_BIT  = 1;
  localparam int unsigned ENA_BIT  = 2;

  // reset values
  localparam logic [SEL_W-1:0] SEL_RST = 5'h00;
  localparam logic             ENA_RST = 1'h0;
  localparam logic             DRV_RST = 1'h0;
  localparam logic             POL_RST = 1'h0;
  localparam logic             WIN_RST = 1'h0;
  localparam logic             TOG_RST = 1'h0;
  localparam logic             PIN_OUT_RST = 1'h0;
  localparam logic             PIN_OE_RST  = 1'h0;
  localparam logic [REG_DW-1:0] RDATA_RST  = 16'h0000;

  // selector codes, same meaning on both pins except legacy code 00
  typedef enum logic [SEL_W-1:0] {
    SEL_LEGACY   = 5'h00,
    SEL_INTR     = 5'h01,
    SEL_WINDOW   = 5'h02,
    SEL_LED_A    = 5'h05,
    SEL_LED_B    = 5'h06,
    SEL_LED_AB   = 5'h07,
    SEL_DATA_A   = 5'h0c,
    SEL_DATA_B   = 5'h0d,
    SEL_DATA_ANY = 5'h0e,
    SEL_TOGGLE   = 5'h0f,
    SEL_LOW      = 5'h10,
    SEL_HIGH     = 5'h11,
    SEL_OSC      = 5'h13
  } gas_sel_t;

endpackage : gas_pkg

//--- tb/gas_pin_host.sv
// far-side observer of the first pin wire with its board pull resistor
`timescale 1ns/10ps
`default_nettype none
module gas_pin_host (
  input  wire logic pin0_out,
  input  wire logic pin0_oe,
  input  wire logic pull_up,
  output logic      pin0_wire
);
  // a released pin settles at the pull level, never at the last driven value
  assign pin0_wire = pin0_oe ? pin0_out : pull_up;
endmodule : gas_pin_host
`default_nettype wire

//--- tb/gas_pin_select_assertions.sv
// port checker for the general pin output selector
`timescale 1ns/10ps
`default_nettype none
module gas_pin_select_assertions (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic        reg_wr_en,
  input wire logic        reg_rd_en,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        intr_level,
  input wire logic        slot_first_start,
  input wire logic        slot_a_led,
  input wire logic        slot_b_led,
  input wire logic        osc_slow_clk,
  input wire logic        first_general_pin_out,
  input wire logic        first_general_pin_oe,
  input wire logic        second_general_pin_out,
  input wire logic        second_general_pin_oe
);
  logic [15:0] alt_q, alt_d;
  logic [2:0]  cfg_q, cfg_d;
  wire  [4:0]  s0 = alt_q[4:0];
  wire  [4:0]  s1 = alt_q[12:8];
  always_comb begin
    alt_d = alt_q;
    cfg_d = cfg_q;
    if (reg_wr_en && reg_addr == gas_pkg::ADDR_ALT_SEL) alt_d = reg_wdata & 16'h1f1f;
    if (reg_wr_en && reg_addr == gas_pkg::ADDR_PIN_CFG) cfg_d = reg_wdata[2:0];
  end
  always_ff @(posedge sys_clk) begin
    alt_q <= sys_rst ? 16'h0000 : alt_d;
    cfg_q <= sys_rst ? 3'h0 : cfg_d;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_win_open;
    slot_first_start ##1 (s0 == 5'h02 && cfg_q == 3'h4);
  endsequence
  a_read_data: assert property (
    reg_rd_en && reg_addr == 8'h0b |=> reg_rdata == $past(alt_q)) else $error("readback");
  a_unmapped_zero: assert property (
    reg_rd_en && reg_addr > 8'h0b |=> reg_rdata == 16'h0000) else $error("unmapped");
  a_second_drive: assert property (!$past(sys_rst) |-> second_general_pin_oe)
    else $error("second pin released");
  a_const_level: assert property (
    s1[4:1] == 4'h8 |=> second_general_pin_out == $past(alt_q[8])) else $error("const");
  a_led_copy: assert property (s1 == 5'h07 |=>
    second_general_pin_out == ($past(slot_a_led) | $past(slot_b_led))) else $error("led");
  a_osc_route: assert property (
    s1 == 5'h13 |=> second_general_pin_out == $past(osc_slow_clk)) else $error("osc");
  a_pin_float: assert property (!cfg_q[2] |=> !first_general_pin_oe)
    else $error("pin driven while disabled");
  a_open_drain: assert property (s0 == 5'h01 && cfg_q == 3'h6 |=>
    first_general_pin_oe == $past(intr_level) && first_general_pin_out == $past(intr_level))
    else $error("open drain");
  a_window_open: assert property (s_win_open |=> first_general_pin_out)
    else $error("window");
endmodule : gas_pin_select_assertions
bind gas_pin_select gas_pin_select_assertions gas_pin_select_assertions_i (.*);
`default_nettype wire

//--- tb/gas_pin_select_tb.sv
// self-checking bench for the general pin output selector
`timescale 1ns/10ps
`default_nettype none
module gas_pin_select_tb;
  logic sys_clk, sys_rst, reg_wr_en, reg_rd_en, intr_level, slot_a_led, slot_b_led;
  logic slot_first_start, slot_last_end, slot_a_data, slot_b_data, sample_tick, osc_slow_clk;
  logic first_general_pin_out, first_general_pin_oe, second_general_pin_out;
  logic second_general_pin_oe, run, wire0, e0, eoe0, e1, eoe1, win, tog;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [4:0]  ms0, ms1, c0, c1;
  logic [2:0]  mcfg, cf;
  logic [31:0] r;
  logic [4:0]  codes [16] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h06, 5'h07, 5'h0c, 5'h0d,
                               5'h0e, 5'h0f, 5'h10, 5'h11, 5'h13, 5'h03, 5'h08, 5'h14};
  int          fail_count, samples_checked;
  int          seed = 32'h6dc9106b;
  gas_pin_select gas_pin_select_i (.*);
  gas_pin_host gas_pin_host_i (.pin0_out(first_general_pin_out), .pin0_oe(first_general_pin_oe),
                               .pull_up(mcfg[0]), .pin0_wire(wire0));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  function automatic logic act(input logic [4:0] s, input logic leg);
    logic [31:0] v;
    v = {12'h000, osc_slow_clk, 3'b010, tog, slot_a_data | slot_b_data, slot_b_data,
         slot_a_data, 4'h0, slot_a_led | slot_b_led, slot_b_led, slot_a_led, 2'b00, win,
         intr_level, leg};
    return v[s];
  endfunction : act
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      {e0, eoe0, e1, eoe1, win, tog, ms0, ms1, mcfg} <= '0;
    end else begin
      e0   <= act(ms0, intr_level) ^ mcfg[0];
      eoe0 <= mcfg[2] & (!mcfg[1] | act(ms0, intr_level));
      e1   <= act(ms1, slot_a_data | slot_b_data);
      eoe1 <= 1'b1;
      win  <= slot_first_start | (win & !slot_last_end);
      tog  <= tog ^ sample_tick;
      if (reg_wr_en && reg_addr == 8'h0b) {ms1, ms0} <= {reg_wdata[12:8], reg_wdata[4:0]};
      if (reg_wr_en && reg_addr == 8'h02) mcfg <= reg_wdata[2:0];
    end
  end
  // slot start/end, data and tick pulse inputs never stay high two cycles running
  always @(posedge sys_clk) if (run) begin
    r = $random(seed);
    {intr_level, slot_a_led, slot_b_led, osc_slow_clk} <= r[3:0];
    {slot_first_start, slot_last_end, slot_a_data, slot_b_data, sample_tick} <=
      r[8:4] & ~{slot_first_start, slot_last_end, slot_a_data, slot_b_data, sample_tick};
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  always @(negedge sys_clk) if (run) begin
    check(first_general_pin_out, e0);
    check(first_general_pin_oe, eoe0);
    check(second_general_pin_out, e1);
    check(second_general_pin_oe, eoe1);
    check(wire0, eoe0 ? e0 : mcfg[0]);
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr_en <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    @(negedge sys_clk);
    check(reg_rdata, exp);
  endtask : rd
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  initial begin
    {reg_wr_en, reg_rd_en, run, intr_level, slot_a_led, slot_b_led, osc_slow_clk} = '0;
    {slot_first_start, slot_last_end, slot_a_data, slot_b_data, sample_tick} = '0;
    {reg_addr, reg_wdata} = '0;
    sys_rst = 1'b1;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    run <= 1'b1;
    rd(8'h0b, 16'h0000);
    rd(8'h02, 16'h0000);
    rd(8'h3c, 16'h0000);
    wr(8'h0b, 16'hffff);
    rd(8'h0b, 16'h1f1f);
    for (int i = 0; i < 32; i++) begin
      c0 = codes[i % 16];
      c1 = codes[(i + 5) % 16];
      cf = (i < 16) ? 3'h4 : {2'b11, i[1]};
      wr(8'h02, {13'h0000, cf});
      wr(8'h0b, {3'b000, c1, 3'b000, c0});
      repeat (40) @(posedge sys_clk);
      rd(8'h0b, {3'b000, c1, 3'b000, c0});
      $display("test %0d done", i);
    end
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h0b, 16'h0000);
    summarize();
  end
  initial begin
    #100000;
    fail_count++;
    summarize();
  end
endmodule : gas_pin_select_tb
`default_nettype wire
